// ==== ppm_port_pin_override_mux.v ====
// Functional notes
// - pull-up override enable set: pull-up follows override value only
// - otherwise pull-up on only for direction 0, output 1, disable 0
// - direction override enable set: driver follows override value
// - otherwise driver follows the direction register bit
// - value override enable with driver on: pin takes override value
// - otherwise driven pin takes the output-value register bit
// - toggle override enable inverts the output-value register bit
// - input-enable override set: input enable follows override value
// - otherwise input enabled unless sleep control is active
// - raw input taken before synchroniser; modules synchronise themselves
// - analog path connects straight to the pad, both directions
// - strobes shared per port, clock sleep pud global, overrides per pin
// - bit seven withdrawn from port when used as crystal pin
// - rc clock, async timer on, no ext clock: bit seven is oscillator out
// - bit seven as clock pin reads zero in direction, output, input
// - each port pin n drives pin-change source n
// - bits 5,4,3,2 carry spi clock, miso, mosi, slave select
// - bit3 timer2 cmp a, bits2,1 timer1 cmp b,a, bit0 capture and clkout
// - without overrides direction one drives, zero is input
// - writing one to an input bit toggles the output-value bit
// - sleep control clamps inputs of pins not overridden
// - pin reaches input register through two stage synchroniser
`include "ppm_defines.vh"
module ppm_port_pin_override_mux
(
	// clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// per-pin overrides from alternate-function modules
	input  wire [7:0]  pullupOverrideEn,
	input  wire [7:0]  pullupOverrideVal,
	input  wire [7:0]  directionOverrideEn,
	input  wire [7:0]  directionOverrideVal,
	input  wire [7:0]  portValueOverrideEn,
	input  wire [7:0]  portValueOverrideVal,
	input  wire [7:0]  portToggleOverrideEn,
	input  wire [7:0]  inputEnableOverrideEn,
	input  wire [7:0]  inputEnableOverrideVal,
	// pads
	input  wire [7:0]  padIn,
	output reg  [7:0]  padOut,
	output reg  [7:0]  padOe,
	output reg  [7:0]  padPullup,
	// to alternate-function modules
	output reg  [7:0]  rawDigitalInput,
	output reg  [7:0]  pinChangeSrc,
	output reg         spiClockIn,
	output reg         spiMisoIn,
	output reg         spiMosiIn,
	output reg         spiSlaveSelectIn,
	output reg         timer1CaptureIn,
	output reg         bitSevenIsClock
);

	reg  [7:0] directionBit_reg;
	reg  [7:0] outputValueBit_reg;
	reg  [7:0] syncFirst_reg;
	reg  [7:0] pinInputBit_reg;
	reg  [5:0] ctrl_reg;
	reg  [7:0] outputValueBit_next;
	reg  [7:0] pullupNext;
	reg  [7:0] driveNext;
	reg  [7:0] valueNext;
	reg  [7:0] inputEnable;
	reg  [7:0] gatedIn;
	reg  [31:0] readData;
	reg        addrHit;
	wire       globalPullupDisable;
	wire       sleepCtrl;
	wire       clockPin;
	wire       accessWr;
	wire [7:0] wrByte;

	assign globalPullupDisable = ctrl_reg[`PPM_CTRL_PUD];
	assign sleepCtrl = ctrl_reg[`PPM_CTRL_SLEEP];
	// crystal use, or rc clock with async timer and crystal (not ext clock)
	assign clockPin = ctrl_reg[`PPM_CTRL_XTAL] | (ctrl_reg[`PPM_CTRL_INTRC] &
		ctrl_reg[`PPM_CTRL_AS2] & ~ctrl_reg[`PPM_CTRL_EXTERNAL_CLOCK_SELECT]);
	assign accessWr = psel & penable & pwrite;
	assign wrByte = pwdata[7:0];

	function mapped;
		input [11:0] a;
		begin
			mapped = (a == `PPM_OFF_INPUT) | (a == `PPM_OFF_DIR) |
				(a == `PPM_OFF_OUTVAL) | (a == `PPM_OFF_CTRL) |
				(a == `PPM_OFF_STATUS);
		end
	endfunction

	// bit seven masked while it serves as clock pin
	function [7:0] hideSeven;
		input [7:0] v;
		input       hide;
		begin
			hideSeven = v;
			if (hide)
			begin
				hideSeven[`PPM_BIT_SEVEN] = 1'b0;
			end
		end
	endfunction

	// output-value next: software write, then pin-input toggle, then override toggle
	always @*
	begin
		outputValueBit_next = outputValueBit_reg;
		// writes land only at the edge where pready is seen high
		if (accessWr && pready && paddr == `PPM_OFF_OUTVAL)
		begin
			outputValueBit_next = wrByte;
		end
		if (accessWr && pready && paddr == `PPM_OFF_INPUT)
		begin
			outputValueBit_next = outputValueBit_next ^ wrByte;
		end
		outputValueBit_next = outputValueBit_next ^ portToggleOverrideEn;
	end

	// per-pin override muxes, all combinational ahead of the pad flops
	genvar n;
	generate
		for (n = 0; n < 8; n = n + 1)
		begin : pinMux
			always @*
			begin
				if (pullupOverrideEn[n])
				begin
					pullupNext[n] = pullupOverrideVal[n];
				end
				else
				begin
					pullupNext[n] = ~directionBit_reg[n] & outputValueBit_reg[n] &
						~globalPullupDisable;
				end
				if (directionOverrideEn[n])
				begin
					driveNext[n] = directionOverrideVal[n];
				end
				else
				begin
					driveNext[n] = directionBit_reg[n];
				end
				if (portValueOverrideEn[n])
				begin
					valueNext[n] = portValueOverrideVal[n];
				end
				else
				begin
					valueNext[n] = outputValueBit_reg[n];
				end
				if (inputEnableOverrideEn[n])
				begin
					inputEnable[n] = inputEnableOverrideVal[n];
				end
				else
				begin
					inputEnable[n] = ~sleepCtrl;
				end
				// clamped input reads low, like the gated schmitt input
				gatedIn[n] = padIn[n] & inputEnable[n];
			end
		end
	endgenerate

	always @*
	begin
		addrHit = mapped(paddr);
		case (paddr)
			`PPM_OFF_INPUT:  readData = {24'h000000, hideSeven(pinInputBit_reg, clockPin)};
			`PPM_OFF_DIR:    readData = {24'h000000, hideSeven(directionBit_reg, clockPin)};
			`PPM_OFF_OUTVAL: readData = {24'h000000, hideSeven(outputValueBit_reg, clockPin)};
			`PPM_OFF_CTRL:   readData = {26'h0000000, ctrl_reg};
			`PPM_OFF_STATUS: readData = {24'h000000, padOe};
			default:         readData = 32'h00000000;
		endcase
	end

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			directionBit_reg <= `PPM_RST_BYTE;
			outputValueBit_reg <= `PPM_RST_BYTE;
			ctrl_reg <= `PPM_RST_CTRL;
			syncFirst_reg <= 8'h00;
			pinInputBit_reg <= 8'h00;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			padOut <= 8'h00;
			padOe <= 8'h00;
			padPullup <= 8'h00;
			rawDigitalInput <= 8'h00;
			pinChangeSrc <= 8'h00;
			spiClockIn <= 1'b0;
			spiMisoIn <= 1'b0;
			spiMosiIn <= 1'b0;
			spiSlaveSelectIn <= 1'b0;
			timer1CaptureIn <= 1'b0;
			bitSevenIsClock <= 1'b0;
		end
		else
		begin
			// apb answers one cycle into the access phase
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addrHit;
			if (psel && penable && !pready && !pwrite)
			begin
				prdata <= readData;
			end
			if (accessWr && pready && paddr == `PPM_OFF_DIR)
			begin
				directionBit_reg <= wrByte;
			end
			if (accessWr && pready && paddr == `PPM_OFF_CTRL)
			begin
				ctrl_reg <= pwdata[`PPM_CTRL_W-1:0];
			end
			outputValueBit_reg <= outputValueBit_next;
			// two flops stand in for the latch-plus-flop; adds half a cycle
			syncFirst_reg <= gatedIn;
			pinInputBit_reg <= syncFirst_reg;
			// withdrawn bit seven must not show a value while its driver is off
			padOut <= valueNext & hideSeven(driveNext, clockPin);
			padOe <= hideSeven(driveNext, clockPin);
			padPullup <= hideSeven(pullupNext, clockPin);
			// raw input bypasses the port synchroniser; users sync it
			rawDigitalInput <= gatedIn;
			pinChangeSrc <= gatedIn;
			spiClockIn <= gatedIn[5];
			spiMisoIn <= gatedIn[4];
			spiMosiIn <= gatedIn[3];
			spiSlaveSelectIn <= gatedIn[2];
			timer1CaptureIn <= gatedIn[0];
			bitSevenIsClock <= clockPin;
		end
	end

	// analog path: the pad net itself carries it, no logic sits between
	// compare outputs and clock out enter via port value overrides

endmodule

// ==== ppm_defines.vh ====
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH
// apb register byte offsets
`define PPM_OFF_INPUT     12'h000
`define PPM_OFF_DIR       12'h004
`define PPM_OFF_OUTVAL    12'h008
`define PPM_OFF_CTRL      12'h00c
`define PPM_OFF_STATUS    12'h010
// control register fields
`define PPM_CTRL_PUD      0
`define PPM_CTRL_SLEEP    1
`define PPM_CTRL_INTRC    2
`define PPM_CTRL_XTAL     3
`define PPM_CTRL_AS2      4
`define PPM_CTRL_EXTERNAL_CLOCK_SELECT    5
`define PPM_CTRL_W        6
// reset values
`define PPM_RST_BYTE      8'h00
`define PPM_RST_CTRL      6'h00
// port bit carrying the second oscillator pin
`define PPM_BIT_SEVEN     7
`endif

// ==== ppm_mux_properties.sv ====
module ppm_mux_properties
(
	// clock, reset, handshake
	input wire       clk, reset_n, psel, penable, pready, bitSevenIsClock,
	// overrides and pads
	input wire [7:0] pullupOverrideEn, pullupOverrideVal, directionOverrideEn,
	input wire [7:0] directionOverrideVal, portValueOverrideEn, portValueOverrideVal,
	input wire [7:0] padOut, padOe, padPullup, rawDigitalInput, pinChangeSrc
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// access phase still waiting
	sequence apbWait;
		psel && penable && !pready;
	endsequence
	apb_answer_a: assert property (apbWait |=> pready)
		else $error("apb answer late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready too long");
	// bit 7 excluded: clock use may force it
	pullup_ovr_a: assert property (((padPullup ^ $past(pullupOverrideVal))
		& $past(pullupOverrideEn) & 8'h7f) == 8'h00) else $error("pullup override");
	dir_ovr_a: assert property (((padOe ^ $past(directionOverrideVal))
		& $past(directionOverrideEn) & 8'h7f) == 8'h00) else $error("direction override");
	value_ovr_a: assert property (((padOut ^ $past(portValueOverrideVal))
		& $past(portValueOverrideEn) & padOe) == 8'h00) else $error("value override");
	driver_off_a: assert property ((padOut & ~padOe) == 8'h00)
		else $error("pad driven while off");
	pin_change_a: assert property (pinChangeSrc == rawDigitalInput)
		else $error("pin change source");
	clock_pin_a: assert property (bitSevenIsClock && $past(bitSevenIsClock)
		|-> !padOe[7] && !padPullup[7]) else $error("bit seven not withdrawn");
endmodule
bind ppm_port_pin_override_mux ppm_mux_properties i_ppm_mux_properties (.*);

// ==== ppm_peripheral_model.sv ====
module ppm_peripheral_model
(
	// bench control and raw input
	input  wire        clk,
	input  wire  [1:0] sel,
	input  wire  [7:0] rawDigitalInput,
	// own synchronised copy
	output logic [7:0] syncIn,
	// override outputs
	output logic [7:0] pullupOverrideEn, pullupOverrideVal, directionOverrideEn,
	output logic [7:0] directionOverrideVal, portValueOverrideEn, portValueOverrideVal,
	output logic [7:0] portToggleOverrideEn, inputEnableOverrideEn, inputEnableOverrideVal
);
	logic [7:0] stage;
	always @(posedge clk)
	begin
		stage  <= rawDigitalInput;
		syncIn <= stage;
		{pullupOverrideEn, pullupOverrideVal, directionOverrideEn, directionOverrideVal,
			portValueOverrideEn, portValueOverrideVal, portToggleOverrideEn,
			inputEnableOverrideEn, inputEnableOverrideVal}
			<= sel == 2'h1 ? 72'hffa5ffa5ffa500ffa5 : sel == 2'h2 ? 72'h010000 : 72'h0;
	end
endmodule

// ==== testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, slvErr, bitSevenIsClock;
	logic        spiClockIn, spiMisoIn, spiMosiIn, spiSlaveSelectIn, timer1CaptureIn;
	logic [1:0]  sel;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  padIn, padOut, padOe, padPullup, rawDigitalInput, pinChangeSrc, syncIn;
	logic [7:0]  pullupOverrideEn, pullupOverrideVal, directionOverrideEn, directionOverrideVal;
	logic [7:0]  portValueOverrideEn, portValueOverrideVal, portToggleOverrideEn;
	logic [7:0]  inputEnableOverrideEn, inputEnableOverrideVal;
	int          miscompares, checksDone;
	ppm_port_pin_override_mux i_ppm_port_pin_override_mux (.*);
	ppm_peripheral_model i_ppm_peripheral_model (.*);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checksDone++;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			miscompares++;
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// hold the request until pready is seen at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		slvErr = pslverr;
		@(posedge clk);
		{psel, penable} <= 2'b00;
		if (pready !== 1'b1)
		begin
			chk("pready", 1, pready);
			finish_test;
		end
	endtask
	task scnPlain;
		wt(1);
		chk("reset oe", 0, padOe);
		apb(1, 12'h004, 32'hf);
		apb(1, 12'h008, 32'hf5);
		wt(2);
		chk("oe", 8'h0f, padOe);
		chk("out", 8'h05, padOut);
		chk("pullup", 8'hf0, padPullup);
		apb(1, 12'h00c, 32'h1);
		wt(2);
		chk("pud", 8'h00, padPullup);
		apb(1, 12'h00c, 32'h0);
	endtask
	task scnToggle;
		apb(1, 12'h000, 32'h3);
		apb(0, 12'h008, 32'h0);
		chk("pin write", 32'hf6, rd);
		@(posedge clk) sel <= 2'h2;
		@(posedge clk) sel <= 2'h0;
		apb(0, 12'h008, 32'h0);
		chk("toggle", 32'hf7, rd);
	endtask
	task scnOverride;
		@(posedge clk) sel <= 2'h1;
		wt(3);
		chk("dir ovr", 8'ha5, padOe);
		chk("val ovr", 8'ha5, padOut);
		chk("pu ovr", 8'ha5, padPullup);
		chk("spi", 32'h9, {spiClockIn, spiMisoIn, spiMosiIn, spiSlaveSelectIn});
		chk("capture", 1, timer1CaptureIn);
		apb(1, 12'h00c, 32'h2);
		wt(2);
		chk("ie ovr", 8'ha5, rawDigitalInput);
		chk("sync", 8'ha5, syncIn);
		@(posedge clk) sel <= 2'h0;
		wt(3);
		chk("sleep", 8'h00, rawDigitalInput);
		apb(1, 12'h00c, 32'h0);
		wt(2);
		chk("awake", 8'hff, rawDigitalInput);
	endtask
	task scnClock;
		apb(1, 12'h004, 32'hff);
		apb(1, 12'h00c, 32'h8);
		apb(0, 12'h004, 32'h0);
		chk("dir7", 32'h7f, rd);
		apb(0, 12'h008, 32'h0);
		chk("out7", 32'h77, rd);
		apb(0, 12'h000, 32'h0);
		chk("in7", 32'h7f, rd);
		chk("xtal", 1, bitSevenIsClock);
		apb(1, 12'h00c, 32'h14);
		wt(2);
		chk("tosc", 1, bitSevenIsClock);
		apb(1, 12'h00c, 32'h34);
		wt(2);
		chk("extclk", 0, bitSevenIsClock);
		apb(0, 12'h020, 32'h0);
		chk("slverr", 1, slvErr);
		chk("unmapped", 0, rd);
	endtask
	task scnInput;
		apb(1, 12'h00c, 32'h0);
		@(posedge clk) padIn <= 8'h3c;
		wt(1);
		chk("raw", 8'h3c, rawDigitalInput);
		chk("pcint", 8'h3c, pinChangeSrc);
		apb(0, 12'h000, 32'h0);
		chk("pin", 32'h3c, rd);
		apb(0, 12'h010, 32'h0);
		chk("status", 32'hff, rd);
		chk("no slverr", 0, slvErr);
	endtask
	initial
	begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, sel} = '0;
		padIn = 8'hff;
		miscompares = 0;
		checksDone = 0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		scnPlain;
		scnToggle;
		scnOverride;
		scnClock;
		scnInput;
		finish_test;
	end
endmodule
